//--- inc/fl_consts.svh
// Named constants for the flash LED control and fault logic.
// Assumes a 200 MHz core clock and an oversampling link clock for the bus pins.
`ifndef FL_CONSTS_SVH
`define FL_CONSTS_SVH

// Bus address and register indices
`define FL_DEV_ADDR      7'h5A
`define FL_REG_CTRL      3'h0
`define FL_REG_FLASH     3'h1
`define FL_REG_TORCH     3'h2
`define FL_REG_LAST      3'h2
// Field positions
`define FL_B_ON          3
`define FL_B_FEN         4
`define FL_B_TEN         4
`define FL_B_FI          5
`define FL_F_FLASH_TIMEOUT_SELECT        7:5
`define FL_F_CUR         3:0
`define FL_F_TORCH       5:0
// Reset values
`define FL_CTRL_RST      1'b0
`define FL_FLASH_RST     8'hE0
`define FL_TORCH_RST     6'h00
`define FL_STAT_PAD      4'h0
`define FL_TORCH_PAD     2'h0
`define FL_RD_NONE       8'h00
// Link sync idle levels: status flags low, sda and scl high
`define FL_LK_IDLE       5'h03
// Bit counting on the bus
`define FL_BITS_BYTE     4'h8
`define FL_TX_LAST       4'h7
// Times in their own units
`define FL_CLK_MHZ       200
`define FL_SHORT_RETRY_MS 100
`define FL_OPEN_RETRY_MS 100
`define FL_EN_LOW_MS     1000
`define FL_FLASH_STEP_US 156250
// Width of the long counters
`define FL_CNT_W         28

`endif

//--- inc/fl_pkg.sv
// Types shared by the flash LED control and fault logic.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package fl_pkg;
	// Protection state of the LED regulators
	typedef enum logic [1:0] {
		FL_RUN   = 2'b00,
		FL_OPEN  = 2'b01,
		FL_SHORT = 2'b10,
		FL_OVP   = 2'b11
	} fl_fault_t;
	// Bus slave phase
	typedef enum logic [2:0] {
		FL_IDLE  = 3'b000,
		FL_RX    = 3'b001,
		FL_ACK   = 3'b010,
		FL_TX    = 3'b011,
		FL_TXACK = 3'b100
	} fl_bus_t;
	// Meaning of the byte being received
	typedef enum logic [1:0] {
		FL_K_ADDR = 2'b00,
		FL_K_REG  = 2'b01,
		FL_K_DATA = 2'b10
	} fl_kind_t;
endpackage
`default_nettype wire

//--- design/fl_ctrl.sv
// Flash LED driver control: two-wire register slave and fault protection.
// Assumes scl/sda oversampled by i2c_clk_i; analog fault inputs are asynchronous.
// What this block does
// - Judge open LEDs only while regulator runs
// - Both open: open state, retry timer, flag
// - One open channel never raises open flag
// - Overvoltage wins, shuts regulators, open flag clears
// - Short forces off, retry after 100 ms
// - Master drives lines, slave drives acknowledges
// - Answer only to bus address 1011010x
// - Decode low three register address bits
// - Three 8-bit registers at 00h to 02h
// - Registers default only on power-on reset
// - Chip-on bit acts as enable pin
// - Short flag set on any shorted LED while regulator runs
// - Thermal flag set on over-temperature input
// - Timeout select gives 156.25 ms steps
// - Flash current code scales percent of maximum
// - Flash enable bit starts and stops flash
// - Inhibit drops flash current to torch setting
// - Torch register config; status bits read-only
// - Torch register layout, upper bits read zero
// - Torch code uses same percent scale
// - Flash ends when safety timeout expires
// - Enable low over one second shuts down
`timescale 1ns/1ps
`default_nettype none
`include "fl_consts.svh"

module fl_ctrl #(
	parameter int unsigned SHORT_RETRY_CYC = `FL_SHORT_RETRY_MS * 1000 * `FL_CLK_MHZ,
	parameter int unsigned OPEN_RETRY_CYC  = `FL_OPEN_RETRY_MS * 1000 * `FL_CLK_MHZ,
	parameter int unsigned EN_LOW_CYC      = `FL_EN_LOW_MS * 1000 * `FL_CLK_MHZ,
	parameter int unsigned FLASH_STEP_CYC  = `FL_FLASH_STEP_US * `FL_CLK_MHZ
) (
	input  wire logic       ref_clk_i,     // Core clock
	input  wire logic       rst_b_i,       // Power-on reset
	input  wire logic       i2c_clk_i,     // Link sampling clock
	input  wire logic       scl_i,         // Bus clock pin
	input  wire logic       sda_i,         // Bus data pin level
	output logic            sda_o,         // Bus data drive value
	output logic            sda_oe_b_o,    // Low while pulling sda
	input  wire logic       en_pin_i,      // Enable pin
	input  wire logic       fi_pin_i,      // Flash inhibit pin
	input  wire logic       ovp_i,         // Output overvoltage
	input  wire logic       tsd_i,         // Junction over-temperature
	input  wire logic       led1_open_i,   // Channel 1 open
	input  wire logic       led2_open_i,   // Channel 2 open
	input  wire logic       led1_short_i,  // Channel 1 shorted
	input  wire logic       led2_short_i,  // Channel 2 shorted
	output logic            chip_on_o,     // Device out of shutdown
	output logic            reg_on_o,      // Boost and LED regulators on
	output logic            flash_mode_o,  // Flash current selected
	output logic            torch_mode_o,  // Torch current selected
	output logic [3:0]      cur_code_o     // Percent code for the sinks
);

	genvar gi;

	// ---------------- Link domain ----------------
	// Pins and status flags are resynchronised before the bus logic looks at them
	// Stages start at the idle bus level so no false edge follows reset
	localparam logic [4:0] LK_IDLE = `FL_LK_IDLE;
	logic [4:0] lk_pin_w;
	logic [4:0] lk_s_w;
	logic [2:0] stat_w;
	assign lk_pin_w = {stat_w, sda_i, scl_i};
	generate
		for (gi = 0; gi < 5; gi++) begin : g_lk
			logic s1_r;
			logic s2_r;
			always_ff @(posedge i2c_clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					s1_r <= LK_IDLE[gi];
					s2_r <= LK_IDLE[gi];
				end else begin
					s1_r <= lk_pin_w[gi];
					s2_r <= s1_r;
				end
			end
			assign lk_s_w[gi] = s2_r;
		end
	endgenerate

	logic       scl_w;
	logic       sda_w;
	logic [2:0] stat_lk_w;
	assign {stat_lk_w, sda_w, scl_w} = lk_s_w;

	// Third stage for edge detection, fed only from the second stage
	logic scl_d_r;
	logic sda_d_r;
	always_ff @(posedge i2c_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scl_d_r <= LK_IDLE[0];
			sda_d_r <= LK_IDLE[1];
		end else begin
			scl_d_r <= scl_w;
			sda_d_r <= sda_w;
		end
	end

	logic rise_w;
	logic fall_w;
	logic start_w;
	logic stop_w;
	assign rise_w  = scl_w & ~scl_d_r;
	assign fall_w  = ~scl_w & scl_d_r;
	assign start_w = scl_w & scl_d_r & sda_d_r & ~sda_w;
	assign stop_w  = scl_w & scl_d_r & ~sda_d_r & sda_w;

	fl_pkg::fl_bus_t  st_r;
	fl_pkg::fl_kind_t kind_r;
	logic [3:0] cnt_r;
	logic [7:0] sh_r;
	logic [7:0] tx_r;
	logic [2:0] ptr_r;
	logic       nack_r;
	logic       go_tx_r;
	logic       oe_b_r;
	logic       on_r;
	logic [7:0] flash_r;
	logic [5:0] torch_r;
	logic       wr_tgl_r;

	// Byte decode; the pointer keeps only the low three address bits
	logic       bdone_w;
	logic       addr_hit_w;
	logic       reg_wr_w;
	logic [7:0] rd_w;
	assign bdone_w    = (st_r == fl_pkg::FL_RX) & fall_w & (cnt_r == `FL_BITS_BYTE);
	assign addr_hit_w = (sh_r[7:1] == `FL_DEV_ADDR);
	assign reg_wr_w   = bdone_w & (kind_r == fl_pkg::FL_K_DATA) & (ptr_r <= `FL_REG_LAST);
	// Status bits are read-only views of the core domain
	assign rd_w = (ptr_r == `FL_REG_CTRL)  ? {`FL_STAT_PAD, on_r, stat_lk_w} :
	              (ptr_r == `FL_REG_FLASH) ? flash_r :
	              (ptr_r == `FL_REG_TORCH) ? {`FL_TORCH_PAD, torch_r} :
	              `FL_RD_NONE;

	// Bus slave sequencing; sda is only ever pulled low, never driven high
	always_ff @(posedge i2c_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r    <= fl_pkg::FL_IDLE;
			kind_r  <= fl_pkg::FL_K_ADDR;
			cnt_r   <= 4'h0;
			sh_r    <= 8'h00;
			tx_r    <= 8'h00;
			ptr_r   <= 3'h0;
			nack_r  <= 1'b0;
			go_tx_r <= 1'b0;
			oe_b_r  <= 1'b1;
		end else if (start_w) begin
			st_r   <= fl_pkg::FL_RX;
			kind_r <= fl_pkg::FL_K_ADDR;
			cnt_r  <= 4'h0;
			oe_b_r <= 1'b1;
		end else if (stop_w) begin
			st_r   <= fl_pkg::FL_IDLE;
			oe_b_r <= 1'b1;
		end else begin
			case (st_r)
				fl_pkg::FL_RX: begin
					if (rise_w) begin
						sh_r  <= {sh_r[6:0], sda_w};
						cnt_r <= cnt_r + 4'h1;
					end else if (bdone_w) begin
						cnt_r <= 4'h0;
						if (kind_r == fl_pkg::FL_K_ADDR && !addr_hit_w) begin
							st_r <= fl_pkg::FL_IDLE;
						end else begin
							st_r    <= fl_pkg::FL_ACK;
							oe_b_r  <= 1'b0;
							go_tx_r <= (kind_r == fl_pkg::FL_K_ADDR) & sh_r[0];
						end
						if (kind_r == fl_pkg::FL_K_REG) begin
							ptr_r <= sh_r[2:0];
						end
						kind_r <= (kind_r == fl_pkg::FL_K_ADDR) ? fl_pkg::FL_K_REG : fl_pkg::FL_K_DATA;
					end
				end
				fl_pkg::FL_ACK: begin
					if (fall_w) begin
						if (go_tx_r) begin
							st_r   <= fl_pkg::FL_TX;
							tx_r   <= {rd_w[6:0], 1'b0};
							oe_b_r <= rd_w[7];
						end else begin
							st_r   <= fl_pkg::FL_RX;
							oe_b_r <= 1'b1;
						end
					end
				end
				fl_pkg::FL_TX: begin
					if (fall_w) begin
						if (cnt_r == `FL_TX_LAST) begin
							st_r   <= fl_pkg::FL_TXACK;
							oe_b_r <= 1'b1;
							cnt_r  <= 4'h0;
						end else begin
							cnt_r  <= cnt_r + 4'h1;
							oe_b_r <= tx_r[7];
							tx_r   <= {tx_r[6:0], 1'b0};
						end
					end
				end
				fl_pkg::FL_TXACK: begin
					if (rise_w) begin
						nack_r <= sda_w;
					end else if (fall_w) begin
						if (nack_r) begin
							st_r <= fl_pkg::FL_IDLE;
						end else begin
							st_r   <= fl_pkg::FL_TX;
							tx_r   <= {rd_w[6:0], 1'b0};
							oe_b_r <= rd_w[7];
						end
					end
				end
				default: begin
					st_r <= fl_pkg::FL_IDLE;
				end
			endcase
		end
	end

	assign sda_o      = 1'b0;
	assign sda_oe_b_o = oe_b_r;

	// Register file; only power-on reset restores defaults
	always_ff @(posedge i2c_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			on_r     <= `FL_CTRL_RST;
			flash_r  <= `FL_FLASH_RST;
			torch_r  <= `FL_TORCH_RST;
			wr_tgl_r <= 1'b0;
		end else if (reg_wr_w) begin
			wr_tgl_r <= ~wr_tgl_r;
			if (ptr_r == `FL_REG_CTRL) begin
				on_r <= sh_r[`FL_B_ON];
			end
			if (ptr_r == `FL_REG_FLASH) begin
				flash_r <= sh_r;
			end
			if (ptr_r == `FL_REG_TORCH) begin
				torch_r <= sh_r[`FL_F_TORCH];
			end
		end
	end

	// ---------------- Core domain ----------------
	// Pins and the write toggle pass two flops before use
	logic [8:0] rf_pin_w;
	logic [8:0] rf_s_w;
	assign rf_pin_w = {wr_tgl_r, led2_short_i, led1_short_i, led2_open_i, led1_open_i,
	                   tsd_i, ovp_i, fi_pin_i, en_pin_i};
	generate
		for (gi = 0; gi < 9; gi++) begin : g_rf
			logic s1_r;
			logic s2_r;
			always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					s1_r <= 1'b0;
					s2_r <= 1'b0;
				end else begin
					s1_r <= rf_pin_w[gi];
					s2_r <= s1_r;
				end
			end
			assign rf_s_w[gi] = s2_r;
		end
	endgenerate

	logic tg_s_w;
	logic sht2_s_w;
	logic sht1_s_w;
	logic op2_s_w;
	logic op1_s_w;
	logic tsd_s_w;
	logic ovp_s_w;
	logic fi_s_w;
	logic en_s_w;
	assign {tg_s_w, sht2_s_w, sht1_s_w, op2_s_w, op1_s_w,
	        tsd_s_w, ovp_s_w, fi_s_w, en_s_w} = rf_s_w;

	// Shadow copy taken on a write event; link fields are stable by then
	logic       tg_d_r;
	logic       sh_on_r;
	logic [7:0] sh_fl_r;
	logic [5:0] sh_to_r;
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tg_d_r  <= 1'b0;
			sh_on_r <= `FL_CTRL_RST;
			sh_fl_r <= `FL_FLASH_RST;
			sh_to_r <= `FL_TORCH_RST;
		end else begin
			tg_d_r <= tg_s_w;
			if (tg_s_w ^ tg_d_r) begin
				sh_on_r <= on_r;
				sh_fl_r <= flash_r;
				sh_to_r <= torch_r;
			end
		end
	end

	// Chip enable with the long-low shutdown
	logic                 chip_act_r;
	logic [`FL_CNT_W-1:0] en_cnt_r;
	logic                 en_req_w;
	logic                 en_exp_w;
	assign en_req_w = sh_on_r | en_s_w;
	assign en_exp_w = (en_cnt_r == `FL_CNT_W'(EN_LOW_CYC));
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			chip_act_r <= 1'b0;
			en_cnt_r   <= '0;
		end else begin
			en_cnt_r   <= (en_req_w | !chip_act_r) ? '0 : en_cnt_r + 1'b1;
			chip_act_r <= en_req_w | (chip_act_r & !en_exp_w);
		end
	end

	// Flash safety timer; cleared by dropping the enable bit
	logic                 fl_to_r;
	logic [`FL_CNT_W-1:0] fl_cnt_r;
	logic [`FL_CNT_W-1:0] fl_lim_w;
	logic                 flash_req_w;
	logic                 torch_req_w;
	logic                 inh_w;
	logic                 led_req_w;
	assign fl_lim_w    = `FL_CNT_W'(FLASH_STEP_CYC * ({29'd0, sh_fl_r[`FL_F_FLASH_TIMEOUT_SELECT]} + 32'd1));
	assign flash_req_w = chip_act_r & sh_fl_r[`FL_B_FEN] & !fl_to_r;
	assign torch_req_w = chip_act_r & sh_to_r[`FL_B_TEN];
	assign inh_w       = fi_s_w | sh_to_r[`FL_B_FI];
	assign led_req_w   = (flash_req_w | torch_req_w) & !tsd_s_w;
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fl_to_r  <= 1'b0;
			fl_cnt_r <= '0;
		end else begin
			fl_cnt_r <= flash_req_w ? fl_cnt_r + 1'b1 : '0;
			// Greater-or-equal so a shorter timeout written mid-flash still ends it
			fl_to_r  <= sh_fl_r[`FL_B_FEN] & (fl_to_r | (flash_req_w & (fl_cnt_r >= fl_lim_w - 1'b1)));
		end
	end

	// Fault detection; overvoltage has priority in every state
	fl_pkg::fl_fault_t    fs_r;
	fl_pkg::fl_fault_t    fs_nxt;
	logic [`FL_CNT_W-1:0] rt_cnt_r;
	logic                 reg_on_r;
	logic                 op_both_w;
	logic                 sht_any_w;
	logic                 rt_short_w;
	logic                 rt_open_w;
	assign op_both_w  = op1_s_w & op2_s_w;
	assign sht_any_w  = sht1_s_w | sht2_s_w;
	assign rt_short_w = (rt_cnt_r == `FL_CNT_W'(SHORT_RETRY_CYC - 1));
	assign rt_open_w  = (rt_cnt_r == `FL_CNT_W'(OPEN_RETRY_CYC - 1));
	always_comb begin
		fs_nxt = fs_r;
		case (fs_r)
			fl_pkg::FL_RUN: begin
				if (ovp_s_w) begin
					fs_nxt = fl_pkg::FL_OVP;
				end else if (reg_on_r & sht_any_w) begin
					fs_nxt = fl_pkg::FL_SHORT;
				end else if (reg_on_r & op_both_w) begin
					fs_nxt = fl_pkg::FL_OPEN;
				end
			end
			fl_pkg::FL_OPEN: begin
				if (ovp_s_w) begin
					fs_nxt = fl_pkg::FL_OVP;
				end else if (rt_open_w) begin
					fs_nxt = fl_pkg::FL_RUN;
				end
			end
			fl_pkg::FL_SHORT: begin
				if (ovp_s_w) begin
					fs_nxt = fl_pkg::FL_OVP;
				end else if (rt_short_w) begin
					fs_nxt = fl_pkg::FL_RUN;
				end
			end
			fl_pkg::FL_OVP: begin
				if (!ovp_s_w) begin
					fs_nxt = fl_pkg::FL_RUN;
				end
			end
			default: begin
				fs_nxt = fl_pkg::FL_RUN;
			end
		endcase
	end

	// Retry counter runs only while parked in a timed fault state
	logic hold_w;
	assign hold_w = (fs_nxt == fs_r) & ((fs_r == fl_pkg::FL_OPEN) | (fs_r == fl_pkg::FL_SHORT));
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fs_r     <= fl_pkg::FL_RUN;
			rt_cnt_r <= '0;
			reg_on_r <= 1'b0;
		end else begin
			fs_r     <= fs_nxt;
			rt_cnt_r <= hold_w ? rt_cnt_r + 1'b1 : '0;
			reg_on_r <= (fs_nxt == fl_pkg::FL_RUN) & led_req_w;
		end
	end

	// Status flags; the thermal flag follows its input, the others clear only on a healthy run or, for the open flag, on overvoltage, so sets never race it
	logic open_flag_r;
	logic short_flag_r;
	logic tsd_flag_r;
	logic ok_run_w;
	assign ok_run_w = (fs_r == fl_pkg::FL_RUN) & reg_on_r;
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			open_flag_r  <= 1'b0;
			short_flag_r <= 1'b0;
			tsd_flag_r   <= 1'b0;
		end else begin
			open_flag_r  <= (fs_r == fl_pkg::FL_RUN && fs_nxt == fl_pkg::FL_OPEN) |
			                (open_flag_r & (fs_nxt != fl_pkg::FL_OVP) &
			                 !(ok_run_w & !op_both_w));
			short_flag_r <= (fs_nxt == fl_pkg::FL_SHORT) |
			                (short_flag_r & !(ok_run_w & !sht_any_w));
			tsd_flag_r   <= tsd_s_w;
		end
	end
	assign stat_w = {short_flag_r, open_flag_r, tsd_flag_r};

	// Sink drive; inhibit swaps the flash code for the torch code
	logic       flash_md_r;
	logic       torch_md_r;
	logic [3:0] cur_r;
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			flash_md_r <= 1'b0;
			torch_md_r <= 1'b0;
			cur_r      <= 4'h0;
		end else begin
			flash_md_r <= flash_req_w & !inh_w;
			torch_md_r <= torch_req_w | (flash_req_w & inh_w);
			cur_r      <= (flash_req_w & !inh_w) ? sh_fl_r[`FL_F_CUR] : sh_to_r[`FL_F_CUR];
		end
	end
	assign chip_on_o    = chip_act_r;
	assign reg_on_o     = reg_on_r;
	assign flash_mode_o = flash_md_r;
	assign torch_mode_o = torch_md_r;
	assign cur_code_o   = cur_r;

	// ---------------- Checks ----------------
	sequence short_seen_s;
		fs_r == fl_pkg::FL_RUN && reg_on_r && sht_any_w && !ovp_s_w;
	endsequence
	sequence forced_off_s;
		fs_r == fl_pkg::FL_SHORT && !reg_on_r;
	endsequence

	short_retry_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		short_seen_s |=> forced_off_s [*4])
		else $error("short did not hold regulators off");
	open_set_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(open_flag_r) |-> $past(reg_on_r) && $past(op1_s_w) && $past(op2_s_w))
		else $error("open flag rose without two open channels");
	ovp_prio_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		ovp_s_w |=> !reg_on_r && !$rose(open_flag_r))
		else $error("overvoltage did not win");
	short_flag_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		fs_r == fl_pkg::FL_SHORT |-> short_flag_r)
		else $error("short flag missing in short state");
	tsd_flag_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		tsd_s_w |=> tsd_flag_r && stat_w[0])
		else $error("thermal flag missing");
	flash_timeout_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		flash_req_w && fl_cnt_r == fl_lim_w - 1'b1 |=> !flash_req_w ##1 !flash_md_r)
		else $error("flash outlived its timeout");
	inhibit_cur_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		flash_req_w && inh_w |=> cur_r == $past(sh_to_r[`FL_F_CUR]) && !flash_md_r)
		else $error("inhibit kept the flash current");
	chip_enable_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		en_req_w |=> chip_act_r)
		else $error("enable request ignored");
	addr_ack_a: assert property (
		@(posedge i2c_clk_i) disable iff (!rst_b_i)
		bdone_w && !start_w && !stop_w && kind_r == fl_pkg::FL_K_ADDR
		|=> (!oe_b_r) == $past(addr_hit_w))
		else $error("address acknowledge wrong");
	ack_release_a: assert property (
		@(posedge i2c_clk_i) disable iff (!rst_b_i)
		st_r == fl_pkg::FL_RX |-> oe_b_r)
		else $error("sda pulled while master drives");

endmodule // fl_ctrl

`default_nettype wire

//--- dv/fl_host_model.sv
// Host model: two-wire bus master that writes and reads control registers.
// Assumes a pull-up on sda and the core clock pacing every bus phase.
`timescale 1ns/1ps
`default_nettype none
module fl_host_model (
	input  wire logic ref_clk_i,  // Pacing clock
	input  wire logic sda_i,      // Resolved data wire
	output logic      scl_o,      // Bus clock, high when idle
	output logic      sda_oe_b_o  // Low while pulling sda
);
	// Idle bus: both lines released
	initial begin
		scl_o = 1'b1;
		sda_oe_b_o = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	// One bit: data moves mid-low, sampled mid-high; a bit spans 320 core cycles, 10 link periods
	task automatic slot(input logic b, output logic s);
		w(100);
		sda_oe_b_o <= b;
		w(60);
		scl_o <= 1'b1;
		w(80);
		s = sda_i;
		w(80);
		scl_o <= 1'b0;
	endtask
	// Start or repeated start: sda falls while scl is high
	task automatic start();
		w(100);
		sda_oe_b_o <= 1'b1;
		w(60);
		scl_o <= 1'b1;
		w(160);
		sda_oe_b_o <= 1'b0;
		w(160);
		scl_o <= 1'b0;
	endtask
	// Stop: sda rises while scl is high
	task automatic stop();
		w(100);
		sda_oe_b_o <= 1'b0;
		w(60);
		scl_o <= 1'b1;
		w(160);
		sda_oe_b_o <= 1'b1;
		w(160);
	endtask
	// Byte out MSB first; the ninth slot is released for the slave
	task automatic byte_out(input logic [7:0] b, output logic nk);
		for (int i = 7; i >= 0; i--) begin
			slot(b[i], nk);
		end
		slot(1'b1, nk);
	endtask
	task automatic addr_only(input logic [7:0] a, output logic nk);
		start();
		byte_out(a, nk);
		stop();
	endtask
	task automatic wr_reg(input logic [7:0] rg, input logic [7:0] d, output logic nk);
		logic a0, a1, a2;
		start();
		byte_out(8'hB4, a0);
		byte_out(rg, a1);
		byte_out(d, a2);
		stop();
		nk = a0 | a1 | a2;
	endtask
	// Pointer write, repeated start, one byte in, then a NACK ends it
	task automatic rd_reg(input logic [7:0] rg, output logic [7:0] d, output logic nk);
		logic a0, a1, a2, s;
		start();
		byte_out(8'hB4, a0);
		byte_out(rg, a1);
		start();
		byte_out(8'hB5, a2);
		for (int i = 7; i >= 0; i--) begin
			slot(1'b1, d[i]);
		end
		slot(1'b1, s);
		stop();
		nk = a0 | a1 | a2;
	endtask
endmodule // fl_host_model
`default_nettype wire

//--- dv/tb_fl_ctrl.sv
// Bench: registers, flash timing and fault handling of the flash LED control.
// Assumes the host model as bus master and shortened retry and timer counts.
`timescale 1ns/1ps
`default_nettype none
module tb_fl_ctrl;
	typedef struct packed {
		logic       wr;
		logic [7:0] rg;
		logic [7:0] dat;
		logic [7:0] exp;
	} fl_row_t;
	// Reset read, control write, torch write with reserved bits set
	fl_row_t    rows [3] = '{
		'{1'b0, 8'h01, 8'h00, 8'hE0},
		'{1'b1, 8'h00, 8'hFF, 8'h08},
		'{1'b1, 8'h02, 8'hFA, 8'h3A}
	};
	logic       ref_clk, i2c_clk, rst_b, en_pin, fi_pin, overvoltage_protection, thermal_shutdown_flag;
	logic       o1, o2, s1, s2, scl, host_oe_b, dut_sda, dut_oe_b;
	logic       chip_on, reg_on, flash_mode, torch_mode;
	logic [3:0] cur_code;
	wire logic  sda_w;
	int         miscompares = 0;
	int         cmp_count = 0;
	// Open-drain wire with pull-up
	assign sda_w = host_oe_b & dut_oe_b;
	fl_host_model i_host (
		.ref_clk_i (ref_clk),
		.sda_i     (sda_w),
		.scl_o     (scl),
		.sda_oe_b_o(host_oe_b)
	);
	fl_ctrl #(
		.SHORT_RETRY_CYC(50),
		.OPEN_RETRY_CYC (50),
		.EN_LOW_CYC     (100),
		.FLASH_STEP_CYC (12000)
	) i_fl_ctrl (
		.ref_clk_i   (ref_clk),
		.rst_b_i     (rst_b),
		.i2c_clk_i   (i2c_clk),
		.scl_i       (scl),
		.sda_i       (sda_w),
		.sda_o       (dut_sda),
		.sda_oe_b_o  (dut_oe_b),
		.en_pin_i    (en_pin),
		.fi_pin_i    (fi_pin),
		.ovp_i       (overvoltage_protection),
		.tsd_i       (thermal_shutdown_flag),
		.led1_open_i (o1),
		.led2_open_i (o2),
		.led1_short_i(s1),
		.led2_short_i(s2),
		.chip_on_o   (chip_on),
		.reg_on_o    (reg_on),
		.flash_mode_o(flash_mode),
		.torch_mode_o(torch_mode),
		.cur_code_o  (cur_code)
	);
	// Core clock 200 MHz
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// Link clock, unrelated phase; it oversamples the pins so it runs free
	initial begin
		i2c_clk = 1'b0;
		#37.3;
		forever #80 i2c_clk = ~i2c_clk;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Bounded wait for a regulator level; n returns the cycles spent
	task automatic wait_reg(input logic v, input int lim, output int n);
		n = 0;
		while (reg_on !== v && n < lim) begin
			@(negedge ref_clk);
			n++;
		end
	endtask
	task automatic tally_and_finish();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Watchdog well beyond the expected 110k cycles
	initial begin
		repeat (150000) @(posedge ref_clk);
		miscompares++;
		tally_and_finish();
	end
	// Main sequence
	initial begin : main
		logic       nk;
		logic [7:0] d;
		int         n;
		{rst_b, en_pin, fi_pin, overvoltage_protection, thermal_shutdown_flag, o1, o2, s1, s2} = '0;
		repeat (5) @(posedge i2c_clk);
		check({6'h00, dut_oe_b, chip_on}, 8'h02);
		@(posedge ref_clk);
		rst_b <= 1'b1;
		tick(60);
		// Enable pin, then a long low on it shuts the chip down
		@(posedge ref_clk);
		en_pin <= 1'b1;
		tick(6);
		check({7'h00, chip_on}, 8'h01);
		@(posedge ref_clk);
		en_pin <= 1'b0;
		tick(80);
		check({7'h00, chip_on}, 8'h01);
		tick(40);
		check({7'h00, chip_on}, 8'h00);
		// Ordinary register rows
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				i_host.wr_reg(rows[i].rg, rows[i].dat, nk);
				check({7'h00, nk}, 8'h00);
			end
			i_host.rd_reg(rows[i].rg, d, nk);
			check({7'h00, nk}, 8'h00);
			check(d, rows[i].exp);
		end
		// Flash held back by the inhibit bit, freed, pin-inhibited, then timed out
		i_host.wr_reg(8'hF9, 8'h15, nk);
		check({2'b00, flash_mode, torch_mode, cur_code}, 8'h1A);
		i_host.wr_reg(8'h02, 8'h1A, nk);
		check({3'b000, flash_mode, cur_code}, 8'h15);
		@(posedge ref_clk);
		fi_pin <= 1'b1;
		tick(6);
		check({2'b00, flash_mode, torch_mode, cur_code}, 8'h1A);
		@(posedge ref_clk);
		fi_pin <= 1'b0;
		tick(13000);
		check({2'b00, flash_mode, torch_mode, cur_code}, 8'h1A);
		// One open channel is tolerated, two trip a timed retry
		check({7'h00, reg_on}, 8'h01);
		@(posedge ref_clk);
		o1 <= 1'b1;
		tick(20);
		check({7'h00, reg_on}, 8'h01);
		@(posedge ref_clk);
		o2 <= 1'b1;
		wait_reg(1'b0, 10, n);
		check({7'h00, reg_on}, 8'h00);
		wait_reg(1'b1, 80, n);
		check({6'h00, reg_on, n > 44}, 8'h03);
		@(posedge ref_clk);
		{o1, o2} <= 2'b00;
		tick(80);
		check({7'h00, reg_on}, 8'h01);
		// Overvoltage forces the regulators off until it clears
		@(posedge ref_clk);
		overvoltage_protection <= 1'b1;
		wait_reg(1'b0, 10, n);
		check({7'h00, reg_on}, 8'h00);
		@(posedge ref_clk);
		overvoltage_protection <= 1'b0;
		wait_reg(1'b1, 20, n);
		check({7'h00, reg_on}, 8'h01);
		// A held short keeps cycling the regulators
		@(posedge ref_clk);
		s1 <= 1'b1;
		wait_reg(1'b0, 10, n);
		check({7'h00, reg_on}, 8'h00);
		wait_reg(1'b1, 80, n);
		check({6'h00, reg_on, n > 44}, 8'h03);
		wait_reg(1'b0, 10, n);
		check({7'h00, reg_on}, 8'h00);
		// Hot die keeps regulators off, so opens now go unjudged
		@(posedge ref_clk);
		{thermal_shutdown_flag, o1, o2, s2} <= 4'hF;
		tick(10);
		i_host.rd_reg(8'h00, d, nk);
		check(d, 8'h0D);
		// Foreign address gets no acknowledge
		i_host.addr_only(8'hB6, nk);
		check({5'h00, nk, dut_oe_b, dut_sda}, 8'h06);
		tally_and_finish();
	end
endmodule // tb_fl_ctrl
`default_nettype wire
